// File: shared/hts_pkg.sv
// How it works
// - After reset the port goes idle after the power-up delay of 182 us.
// - After acknowledging soft reset, the port is busy for 173 us, then idle.
// - A combined conversion lasts 10.8 ms, counted on the system clock.
// - During a stretching conversion the port holds SCL low after acknowledging a read header; master waits.
// - Only bus address 0x70 is answered; other addresses are ignored.
// - Commands are 16-bit codes received over the serial bus.
// - In idle state new commands are accepted.
// - When not converting or resetting, the port returns to idle by itself.
// - Every measurement command runs both humidity and temperature conversion.
// - Stretching codes: 0x7CA2 temperature first, 0x5C24 humidity first.
// - Non-stretching codes: 0x7866 temperature first, 0x58E0 humidity first.
// - Each accepted byte is acknowledged by pulling SDA low after the 8th fall.
// - The first command byte is always acknowledged; the second only if it completes a known command.
// - Conversion starts when the last command byte is acknowledged.
// - Converting without stretching, read and write headers get no acknowledge.
// - Converting with stretching, a read header is acknowledged and SCL held low.
// - Results go out as word, CRC, word, CRC; a master NACK ends sending.
// - Each CRC is CRC-8, polynomial 0x31, init 0xFF, no reflection or XOR.
package hts_pkg;

  // System clock rate
  localparam int CLK_MHZ = 20;

  // Power-up delay, soft reset delay and conversion duration
  localparam int  PU_DLY_US      = 182;
  localparam int  PU_CYC         = PU_DLY_US * CLK_MHZ;
  localparam int  SR_DLY_US      = 173;
  localparam int  SR_CYC         = SR_DLY_US * CLK_MHZ;
  localparam real CONV_DUR_MS    = 10.8;
  localparam int  CONV_CYC       = int'(CONV_DUR_MS * 1000.0 * CLK_MHZ);
  localparam int  CNT_W          = 24;

  // Bus address and command codes
  localparam logic [6:0]  DEV_ADDR   = 7'h70;
  localparam logic [15:0] CMD_CS_T   = 16'h7CA2;
  localparam logic [15:0] CMD_CS_H   = 16'h5C24;
  localparam logic [15:0] CMD_NS_T   = 16'h7866;
  localparam logic [15:0] CMD_NS_H   = 16'h58E0;
  localparam logic [15:0] CMD_SRST   = 16'h805D;

  // Checksum settings and frame length
  localparam logic [7:0]  CRC_POLY   = 8'h31;
  localparam logic [7:0]  CRC_INIT   = 8'hFF;
  localparam logic [2:0]  LAST_BYTE  = 3'h5;

  // Core state on the system clock
  typedef enum {SY_PWRUP, SY_IDLE, SY_CONV, SY_SRST} hts_sys_st_t;

  // Link state on the link clock
  typedef enum {LK_IDLE, LK_RX, LK_RACK, LK_STRETCH, LK_SREL, LK_TX, LK_TACK} hts_lnk_st_t;

  // Which byte of a write transfer is being received
  typedef enum {PH_ADDR, PH_HI, PH_LO} hts_ph_t;

endpackage : hts_pkg

// File: test/hts_i2c_mst.sv
module hts_i2c_mst (
  // Pacing clock
  input  wire logic clk_sys,
  // Wire levels
  input  wire logic scl_w,
  input  wire logic sda_w,
  // Pull-down drives and stall flag
  output logic      scl_dn,
  output logic      sda_dn,
  output logic      tmo
);
  timeunit 1ns;
  timeprecision 1ns;
  // Low is two quarters, high one quarter plus a clock: 2.6 us per bit, about 385 kHz
  localparam int QTR = 17;
  // Lines start released
  initial begin
    scl_dn = 1'b0;
    sda_dn = 1'b0;
    tmo    = 1'b0;
  end
  task automatic qw();
    repeat (QTR) @(posedge clk_sys);
  endtask : qw
  // Release SCL; a stretch is waited out, but never forever
  task automatic sclh();
    int n;
    n = 0;
    scl_dn <= 1'b0;
    @(posedge clk_sys);
    while (scl_w !== 1'b1 && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 4000) tmo <= 1'b1;
    qw();
  endtask : sclh
  // One bit; lines are only pulled low, pull-ups give the high
  task automatic bit_io(input logic b, output logic r);
    sda_dn <= ~b;
    qw();
    sclh();
    r = sda_w;
    scl_dn <= 1'b1;
    qw();
  endtask : bit_io
  task automatic start();
    sda_dn <= 1'b0;
    qw();
    sclh();
    sda_dn <= 1'b1;
    qw();
    scl_dn <= 1'b1;
    qw();
  endtask : start
  task automatic stop();
    sda_dn <= 1'b1;
    qw();
    sclh();
    sda_dn <= 1'b0;
    qw();
    qw();
  endtask : stop
  // Header or command byte, MSB first
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = (r === 1'b0);
  endtask : wr
  // Data byte; mack low answers NACK and ends the read
  task automatic rd(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~mack, r);
  endtask : rd
endmodule : hts_i2c_mst

// File: test/hts_i2c_target_tb.sv
module hts_i2c_target_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Conversion must outlast a read header for the stretch case
  localparam int CONV = 1000;
  logic        clk_sys, clk_link, rst_b, a;
  logic [15:0] hum_val, temp_val;
  logic        scl_oe, sda_oe, dev_idle, conv_active, res_ready;
  logic        scl_o, sda_o;
  logic        scl_dn, sda_dn, tmo;
  logic [7:0]  b [6];
  int          errors, compares, run, last_run, n;
  wire         scl_w = ~(scl_dn | scl_oe);
  wire         sda_w = ~(sda_dn | sda_oe);
  // Clocks, link unrelated in phase
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    clk_link = 1'b0;
    #13;
    forever #80 clk_link = ~clk_link;
  end
  hts_i2c_target #(.CONV_CYC(CONV)) u_hts_i2c_target (.clk_sys(clk_sys), .rst_b(rst_b), .clk_link(clk_link),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .hum_val(hum_val), .temp_val(temp_val), .dev_idle(dev_idle), .conv_active(conv_active),
    .res_ready(res_ready));
  hts_i2c_mst u_hts_i2c_mst (.clk_sys(clk_sys), .scl_w(scl_w), .sda_w(sda_w), .scl_dn(scl_dn),
    .sda_dn(sda_dn), .tmo(tmo));
  // Length of the last conversion run
  always @(posedge clk_sys) begin
    if (conv_active === 1'b1) run <= run + 1;
    else begin
      if (run != 0) last_run <= run;
      run <= 0;
    end
  end
  // A stalled master ends the run
  always @(posedge clk_sys) begin
    if (tmo === 1'b1) begin
      errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction : crc8
  // Bounded wait on a status flag, sampled at the falling edge
  task automatic wait_for(input int sel, input logic v, input int lim, output int k);
    k = 0;
    @(negedge clk_sys);
    while ((sel == 0 ? dev_idle : sel == 1 ? conv_active : res_ready) !== v && k < lim) begin
      @(negedge clk_sys);
      k++;
    end
    @(posedge clk_sys);
    if (k >= lim) begin
      errors++;
      finish_test();
    end
  endtask : wait_for
  task automatic t_addr();
    logic [7:0] hdr [2] = '{8'hE2, 8'h60};
    foreach (hdr[i]) begin
      u_hts_i2c_mst.start();
      u_hts_i2c_mst.wr(hdr[i], a);
      check(a, 0);
      u_hts_i2c_mst.stop();
    end
  endtask : t_addr
  task automatic t_meas(input logic [15:0] code, input logic st, input logic tf, input int nb);
    logic [15:0] w1, w2;
    w1 = tf ? ~code : code ^ 16'hA5C3;
    w2 = tf ? code ^ 16'hA5C3 : ~code;
    hum_val <= code ^ 16'hA5C3;
    temp_val <= ~code;
    u_hts_i2c_mst.start();
    u_hts_i2c_mst.wr(8'hE0, a);
    check(a, 1);
    u_hts_i2c_mst.wr(code[15:8], a);
    check(a, 1);
    u_hts_i2c_mst.wr(code[7:0], a);
    check(a, 1);
    wait_for(1, 1'b1, 4, n);
    u_hts_i2c_mst.start();
    u_hts_i2c_mst.wr(8'hE1, a);
    if (!st) begin
      check(a, 0);
      u_hts_i2c_mst.stop();
      wait_for(2, 1'b1, 1200, n);
      u_hts_i2c_mst.start();
      u_hts_i2c_mst.wr(8'hE1, a);
    end
    check(a, 1);
    if (st) begin
      repeat (20) @(negedge clk_sys);
      check({conv_active, scl_oe}, 3);
      check({scl_o, sda_o}, 0);
      @(posedge clk_sys);
    end
    for (int i = 0; i < nb; i++) u_hts_i2c_mst.rd(i < nb - 1, b[i]);
    if (nb < 6) begin
      u_hts_i2c_mst.rd(1'b0, b[5]);
      check(b[5], 8'hFF);
    end
    u_hts_i2c_mst.stop();
    check({b[0], b[1]}, w1);
    if (nb == 6) begin
      check(b[2], crc8(w1));
      check({b[3], b[4]}, w2);
      check(b[5], crc8(w2));
    end
    check(16'(last_run), 16'(CONV));
    check(dev_idle, 1);
  endtask : t_meas
  // Power-up delay counted from the release of reset
  task automatic t_pwrup();
    check(dev_idle, 0);
    wait_for(0, 1'b1, 4000, n);
    check(16'(n >= 3636 && n <= 3644), 1);
  endtask : t_pwrup
  task automatic t_cmd(input logic [15:0] code, input logic ack2);
    u_hts_i2c_mst.start();
    u_hts_i2c_mst.wr(8'hE0, a);
    check(a, 1);
    u_hts_i2c_mst.wr(code[15:8], a);
    u_hts_i2c_mst.wr(code[7:0], a);
    check(a, ack2);
    u_hts_i2c_mst.stop();
    if (!ack2) check(conv_active, 0);
  endtask : t_cmd
  // Soft reset: busy for its delay, old results gone, so a read header is refused
  task automatic t_srst();
    t_cmd(16'h805D, 1);
    check({res_ready, dev_idle}, 0);
    wait_for(0, 1'b1, 4000, n);
    check(16'(n >= 3300 && n <= 3460), 1);
    u_hts_i2c_mst.start();
    u_hts_i2c_mst.wr(8'hE1, a);
    check(a, 0);
    u_hts_i2c_mst.stop();
  endtask : t_srst
  // Main sequence
  initial begin
    rst_b = 1'b0;
    hum_val = 16'hBEEF;
    temp_val = 16'h6A3C;
    errors = 0;
    compares = 0;
    run = 0;
    last_run = 0;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_pwrup();
    t_addr();
    t_meas(16'h7CA2, 1, 1, 6);
    t_meas(16'h5C24, 1, 0, 6);
    t_meas(16'h7866, 0, 1, 6);
    t_meas(16'h58E0, 0, 0, 2);
    t_cmd(16'h1234, 0);
    t_srst();
    finish_test();
  end
  // Watchdog
  initial begin
    repeat (95000) @(posedge clk_sys);
    errors++;
    finish_test();
  end
endmodule : hts_i2c_target_tb

// File: verilog/hts_crc8.sv
module hts_crc8 (
  // Data word, high byte first
  input  wire logic [15:0] data,
  // Checksum over the word
  output logic      [7:0]  crc
);

  // Bitwise CRC, most significant bit first, no final inversion
  always_comb begin
    crc = hts_pkg::CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (crc[7] ^ data[i]) begin
        crc = {crc[6:0], 1'b0} ^ hts_pkg::CRC_POLY;
      end else begin
        crc = {crc[6:0], 1'b0};
      end
    end
  end

endmodule : hts_crc8

// File: verilog/hts_i2c_target.sv
module hts_i2c_target #(
  parameter int CONV_CYC = hts_pkg::CONV_CYC
) (
  // System clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // Link sampling clock
  input  wire logic        clk_link,
  // Serial clock pin
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  // Serial data pin
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // Converter results, valid at the end of a conversion
  input  wire logic [15:0] hum_val,
  input  wire logic [15:0] temp_val,
  // Status
  output logic             dev_idle,
  output logic             conv_active,
  output logic             res_ready
);

  localparam int CNT_W = hts_pkg::CNT_W;

  // System domain state
  hts_pkg::hts_sys_st_t sys_st_q, sys_st_d;
  logic [CNT_W-1:0]     cnt_q, cnt_d;
  logic [CNT_W-1:0]     hcnt_q, hcnt_d;
  logic                 meas_p_q, meas_p_d;
  logic                 srst_p_q, srst_p_d;
  logic                 rdy_q, rdy_d;
  logic                 busy_q, busy_d;
  logic                 idle_q, idle_d;
  logic                 conv_q, conv_d;
  logic [15:0]          hum_q, hum_d;
  logic [15:0]          temp_q, temp_d;
  logic [7:0]           hcrc_q, hcrc_d;
  logic [7:0]           tcrc_q, tcrc_d;
  logic [7:0]           hcrc_c, tcrc_c;
  logic                 meas_tgl_s, srst_tgl_s;

  // Link domain state
  hts_pkg::hts_lnk_st_t st_q, st_d;
  hts_pkg::hts_ph_t     ph_q, ph_d;
  logic [7:0]           sh_q, sh_d;
  logic [3:0]           bit_q, bit_d;
  logic [7:0]           cmd_hi_q, cmd_hi_d;
  logic [2:0]           byte_q, byte_d;
  logic                 rd_q, rd_d;
  logic                 stretch_q, stretch_d;
  logic                 hfirst_q, hfirst_d;
  logic                 ack_q, ack_d;
  logic                 pend_q, pend_d;
  logic                 meas_tgl_q, meas_tgl_d;
  logic                 srst_tgl_q, srst_tgl_d;
  logic                 sda_oe_q, sda_oe_d;
  logic                 scl_oe_q, scl_oe_d;
  logic                 scl_p_q, sda_p_q;
  logic                 lvl_q;
  logic                 rst_lk_b, scl_s, sda_s, busy_s, rdy_s;

  // Link decode terms
  logic                 start_c, stop_c, rise_c, fall_c, busy_c;
  logic [15:0]          code_c;
  logic                 is_meas_c, is_srst_c;
  logic [47:0]          frame_c;

  // Crossings: pins, reset and status into the link domain; command toggles into the system domain
  hts_sync #(.W(5)) u_lk_sync (
    .clk (clk_link),
    .d   ({rst_b, scl_i, sda_i, busy_q, rdy_q}),
    .q   ({rst_lk_b, scl_s, sda_s, busy_s, rdy_s})
  );

  hts_sync #(.W(2)) u_sys_sync (
    .clk (clk_sys),
    .d   ({meas_tgl_q, srst_tgl_q}),
    .q   ({meas_tgl_s, srst_tgl_s})
  );

  // Checksums for both words, taken when a conversion completes
  hts_crc8 u_crc_hum (
    .data (hum_val),
    .crc  (hcrc_c)
  );

  hts_crc8 u_crc_temp (
    .data (temp_val),
    .crc  (tcrc_c)
  );

  // One bit of a byte of the result frame, first byte is index 0, bit 0 is the MSB
  function automatic logic tx_bit(input logic [47:0] f, input logic [2:0] b, input logic [2:0] i);
    logic [7:0] by;
    by = f[{3'(3'd5 - b), 3'b000} +: 8];
    return by[3'd7 - i];
  endfunction : tx_bit

  // System sequencer: power-up, conversion and soft-reset timing
  always_comb begin
    sys_st_d = sys_st_q;
    cnt_d    = cnt_q + CNT_W'(1);
    hcnt_d   = (sys_st_q == hts_pkg::SY_IDLE) ? '0 : hcnt_q + CNT_W'(1);
    meas_p_d = meas_tgl_s;
    srst_p_d = srst_tgl_s;
    rdy_d    = rdy_q;
    hum_d    = hum_q;
    temp_d   = temp_q;
    hcrc_d   = hcrc_q;
    tcrc_d   = tcrc_q;
    case (sys_st_q)
      hts_pkg::SY_PWRUP: begin
        if (cnt_q == CNT_W'(hts_pkg::PU_CYC - 1)) begin
          sys_st_d = hts_pkg::SY_IDLE;
          cnt_d    = '0;
        end
      end
      hts_pkg::SY_IDLE: begin
        cnt_d = '0;
        if (meas_tgl_s != meas_p_q) begin
          sys_st_d = hts_pkg::SY_CONV;
          rdy_d    = 1'b0;
        end else if (srst_tgl_s != srst_p_q) begin
          sys_st_d = hts_pkg::SY_SRST;
          rdy_d    = 1'b0;
        end
      end
      hts_pkg::SY_CONV: begin
        if (cnt_q == CNT_W'(CONV_CYC - 1)) begin
          sys_st_d = hts_pkg::SY_IDLE;
          cnt_d    = '0;
          hum_d    = hum_val;
          temp_d   = temp_val;
          hcrc_d   = hcrc_c;
          tcrc_d   = tcrc_c;
          rdy_d    = 1'b1;
        end
      end
      hts_pkg::SY_SRST: begin
        if (cnt_q == CNT_W'(hts_pkg::SR_CYC - 1)) begin
          sys_st_d = hts_pkg::SY_IDLE;
          cnt_d    = '0;
        end
      end
      default: begin
        sys_st_d = hts_pkg::SY_PWRUP;
        cnt_d    = '0;
      end
    endcase
    busy_d = (sys_st_d != hts_pkg::SY_IDLE);
    idle_d = (sys_st_d == hts_pkg::SY_IDLE);
    conv_d = (sys_st_d == hts_pkg::SY_CONV);
  end

  // System registers; toggle history restarts at zero with the link
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sys_st_q <= hts_pkg::SY_PWRUP;
      cnt_q    <= '0;
      hcnt_q   <= '0;
      meas_p_q <= 1'b0;
      srst_p_q <= 1'b0;
      rdy_q    <= 1'b0;
      busy_q   <= 1'b1;
      idle_q   <= 1'b0;
      conv_q   <= 1'b0;
      hum_q    <= 16'h0000;
      temp_q   <= 16'h0000;
      hcrc_q   <= 8'h00;
      tcrc_q   <= 8'h00;
    end else begin
      sys_st_q <= sys_st_d;
      cnt_q    <= cnt_d;
      hcnt_q   <= hcnt_d;
      meas_p_q <= meas_p_d;
      srst_p_q <= srst_p_d;
      rdy_q    <= rdy_d;
      busy_q   <= busy_d;
      idle_q   <= idle_d;
      conv_q   <= conv_d;
      hum_q    <= hum_d;
      temp_q   <= temp_d;
      hcrc_q   <= hcrc_d;
      tcrc_q   <= tcrc_d;
    end
  end

  // Bus conditions from the synchronised pins
  assign start_c   = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_c    = scl_s && scl_p_q && !sda_p_q && sda_s;
  assign rise_c    = scl_s && !scl_p_q;
  assign fall_c    = !scl_s && scl_p_q;
  // Pending covers the gap before the new busy level arrives from the system side
  assign busy_c    = busy_s || pend_q;
  assign code_c    = {cmd_hi_q, sh_q};
  assign is_meas_c = (code_c == hts_pkg::CMD_CS_T) || (code_c == hts_pkg::CMD_CS_H) ||
                     (code_c == hts_pkg::CMD_NS_T) || (code_c == hts_pkg::CMD_NS_H);
  assign is_srst_c = (code_c == hts_pkg::CMD_SRST);
  // Result words are static while ready is high, so the link may read them directly
  assign frame_c   = hfirst_q ? {hum_q, hcrc_q, temp_q, tcrc_q} : {temp_q, tcrc_q, hum_q, hcrc_q};

  // Link engine: receive, acknowledge, stretch and transmit
  always_comb begin
    st_d       = st_q;
    ph_d       = ph_q;
    sh_d       = sh_q;
    bit_d      = bit_q;
    cmd_hi_d   = cmd_hi_q;
    byte_d     = byte_q;
    rd_d       = rd_q;
    stretch_d  = stretch_q;
    hfirst_d   = hfirst_q;
    ack_d      = ack_q;
    pend_d     = busy_s ? 1'b0 : pend_q;
    meas_tgl_d = meas_tgl_q;
    srst_tgl_d = srst_tgl_q;
    sda_oe_d   = sda_oe_q;
    scl_oe_d   = scl_oe_q;
    if (start_c) begin
      st_d     = hts_pkg::LK_RX;
      ph_d     = hts_pkg::PH_ADDR;
      bit_d    = 4'h0;
      sda_oe_d = 1'b0;
      scl_oe_d = 1'b0;
    end else if (stop_c) begin
      st_d     = hts_pkg::LK_IDLE;
      sda_oe_d = 1'b0;
      scl_oe_d = 1'b0;
    end else begin
      case (st_q)
        hts_pkg::LK_RX: begin
          if (rise_c) begin
            sh_d  = {sh_q[6:0], sda_s};
            bit_d = bit_q + 4'h1;
          end else if (fall_c && bit_q == 4'h8) begin
            ack_d = 1'b0;
            st_d  = hts_pkg::LK_IDLE;
            case (ph_q)
              hts_pkg::PH_ADDR: begin
                if (sh_q[7:1] == hts_pkg::DEV_ADDR) begin
                  rd_d = sh_q[0];
                  if (!sh_q[0]) begin
                    ack_d = !busy_c;
                  end else begin
                    ack_d = busy_c ? stretch_q : rdy_s;
                  end
                end
              end
              hts_pkg::PH_HI: begin
                ack_d    = 1'b1;
                cmd_hi_d = sh_q;
              end
              default: begin
                ack_d = is_meas_c || is_srst_c;
                if (is_meas_c) begin
                  meas_tgl_d = !meas_tgl_q;
                  pend_d     = 1'b1;
                  stretch_d  = (code_c == hts_pkg::CMD_CS_T) || (code_c == hts_pkg::CMD_CS_H);
                  hfirst_d   = (code_c == hts_pkg::CMD_CS_H) || (code_c == hts_pkg::CMD_NS_H);
                end
                if (is_srst_c) begin
                  srst_tgl_d = !srst_tgl_q;
                  pend_d     = 1'b1;
                  stretch_d  = 1'b0;
                end
              end
            endcase
            if (ack_d) begin
              sda_oe_d = 1'b1;
              st_d     = hts_pkg::LK_RACK;
            end
          end
        end
        hts_pkg::LK_RACK: begin
          if (fall_c) begin
            sda_oe_d = 1'b0;
            bit_d    = 4'h0;
            byte_d   = 3'h0;
            st_d     = hts_pkg::LK_RX;
            case (ph_q)
              hts_pkg::PH_ADDR: begin
                if (!rd_q) begin
                  ph_d = hts_pkg::PH_HI;
                end else if (busy_c) begin
                  st_d     = hts_pkg::LK_STRETCH;
                  scl_oe_d = 1'b1;
                end else begin
                  st_d     = hts_pkg::LK_TX;
                  sda_oe_d = !tx_bit(frame_c, 3'h0, 3'h0);
                end
              end
              hts_pkg::PH_HI: ph_d = hts_pkg::PH_LO;
              default:        st_d = hts_pkg::LK_IDLE;
            endcase
          end
        end
        hts_pkg::LK_STRETCH: begin
          // First data bit is set up while SCL is still held
          if (!busy_c && rdy_s) begin
            sda_oe_d = !tx_bit(frame_c, 3'h0, 3'h0);
            st_d     = hts_pkg::LK_SREL;
          end
        end
        hts_pkg::LK_SREL: begin
          scl_oe_d = 1'b0;
          st_d     = hts_pkg::LK_TX;
        end
        hts_pkg::LK_TX: begin
          if (fall_c) begin
            if (bit_q[2:0] == 3'h7) begin
              sda_oe_d = 1'b0;
              st_d     = hts_pkg::LK_TACK;
            end else begin
              bit_d    = bit_q + 4'h1;
              sda_oe_d = !tx_bit(frame_c, byte_q, bit_q[2:0] + 3'h1);
            end
          end
        end
        hts_pkg::LK_TACK: begin
          if (rise_c) begin
            ack_d = !sda_s;
          end else if (fall_c) begin
            if (ack_q && byte_q != hts_pkg::LAST_BYTE) begin
              byte_d   = byte_q + 3'h1;
              bit_d    = 4'h0;
              sda_oe_d = !tx_bit(frame_c, byte_q + 3'h1, 3'h0);
              st_d     = hts_pkg::LK_TX;
            end else begin
              st_d = hts_pkg::LK_IDLE;
            end
          end
        end
        default: st_d = hts_pkg::LK_IDLE;
      endcase
    end
  end

  // Link registers; pins drive low only, so the driven level is always zero
  always_ff @(posedge clk_link) begin
    scl_p_q <= scl_s;
    sda_p_q <= sda_s;
    if (!rst_lk_b) begin
      st_q       <= hts_pkg::LK_IDLE;
      ph_q       <= hts_pkg::PH_ADDR;
      sh_q       <= 8'h00;
      bit_q      <= 4'h0;
      cmd_hi_q   <= 8'h00;
      byte_q     <= 3'h0;
      rd_q       <= 1'b0;
      stretch_q  <= 1'b0;
      hfirst_q   <= 1'b0;
      ack_q      <= 1'b0;
      pend_q     <= 1'b0;
      meas_tgl_q <= 1'b0;
      srst_tgl_q <= 1'b0;
      sda_oe_q   <= 1'b0;
      scl_oe_q   <= 1'b0;
      lvl_q      <= 1'b0;
    end else begin
      st_q       <= st_d;
      ph_q       <= ph_d;
      sh_q       <= sh_d;
      bit_q      <= bit_d;
      cmd_hi_q   <= cmd_hi_d;
      byte_q     <= byte_d;
      rd_q       <= rd_d;
      stretch_q  <= stretch_d;
      hfirst_q   <= hfirst_d;
      ack_q      <= ack_d;
      pend_q     <= pend_d;
      meas_tgl_q <= meas_tgl_d;
      srst_tgl_q <= srst_tgl_d;
      sda_oe_q   <= sda_oe_d;
      scl_oe_q   <= scl_oe_d;
      lvl_q      <= 1'b0;
    end
  end

  // Outputs straight from registers
  assign scl_o       = lvl_q;
  assign sda_o       = lvl_q;
  assign scl_oe      = scl_oe_q;
  assign sda_oe      = sda_oe_q;
  assign dev_idle    = idle_q;
  assign conv_active = conv_q;
  assign res_ready   = rdy_q;

  AST_PWRUP_LEN: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    ($past(sys_st_q) == hts_pkg::SY_PWRUP && sys_st_q == hts_pkg::SY_IDLE) |-> hcnt_q == CNT_W'(hts_pkg::PU_CYC))
    else $error("Power-up delay has wrong length");

  AST_SRST_LEN: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    ($past(sys_st_q) == hts_pkg::SY_SRST && sys_st_q == hts_pkg::SY_IDLE) |-> hcnt_q == CNT_W'(hts_pkg::SR_CYC))
    else $error("Soft reset delay has wrong length");

  AST_CONV_LEN: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    $fell(conv_q) |-> hcnt_q == CNT_W'(CONV_CYC))
    else $error("Conversion has wrong length");

  AST_BOTH_RESULTS: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    $fell(conv_q) |-> res_ready && dev_idle && hcrc_q == $past(hcrc_c) && tcrc_q == $past(tcrc_c))
    else $error("Conversion ended without both results");

  AST_ADDR_MISS: assert property (
    @(posedge clk_link) disable iff (!rst_lk_b)
    (st_q == hts_pkg::LK_RX && ph_q == hts_pkg::PH_ADDR && bit_q == 4'h8 && fall_c && !start_c && !stop_c &&
     sh_q[7:1] != hts_pkg::DEV_ADDR) |=> !sda_oe_q && st_q == hts_pkg::LK_IDLE)
    else $error("Foreign address acknowledged");

  AST_BUSY_NACK: assert property (
    @(posedge clk_link) disable iff (!rst_lk_b)
    (st_q == hts_pkg::LK_RX && ph_q == hts_pkg::PH_ADDR && bit_q == 4'h8 && fall_c && !start_c && !stop_c &&
     busy_c && !stretch_q) |=> !sda_oe_q)
    else $error("Header acknowledged while converting without stretching");

  AST_ACK_HELD: assert property (
    @(posedge clk_link) disable iff (!rst_lk_b)
    (st_q == hts_pkg::LK_RACK && !fall_c && !start_c && !stop_c) |=> sda_oe_q)
    else $error("Acknowledge released early");

  AST_MEAS_START: assert property (
    @(posedge clk_link) disable iff (!rst_lk_b)
    (st_q == hts_pkg::LK_RX && ph_q == hts_pkg::PH_LO && bit_q == 4'h8 && fall_c && !start_c && !stop_c &&
     is_meas_c) |=> meas_tgl_q != $past(meas_tgl_q) && sda_oe_q && pend_q)
    else $error("Conversion not started with command acknowledge");

  AST_STRETCH_HOLD: assert property (
    @(posedge clk_link) disable iff (!rst_lk_b)
    (st_q == hts_pkg::LK_STRETCH && busy_c && !start_c && !stop_c) |=> scl_oe_q[*2])
    else $error("Clock released while conversion runs");

  AST_TX_STOP: assert property (
    @(posedge clk_link) disable iff (!rst_lk_b)
    (st_q == hts_pkg::LK_TACK && fall_c && !ack_q && !start_c && !stop_c) |=> !sda_oe_q && st_q == hts_pkg::LK_IDLE)
    else $error("Sending continued after master NACK");

endmodule : hts_i2c_target

// File: verilog/hts_sync.sv
module hts_sync #(
  parameter int W = 1
) (
  // Destination clock
  input  wire logic         clk,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // Two stages; the first stage feeds only the second
  always_ff @(posedge clk) begin
    meta_q <= d;
    q      <= meta_q;
  end

endmodule : hts_sync
